/* shared/wdt_pkg.sv */
// constants for the i/o port watchdog timer
package wdt_pkg;

  // ----------------------------------------------------------------
  // port map
  // ----------------------------------------------------------------
  localparam logic [15:0] WATCHDOG_INTERVAL_PORT = 16'h0443;
  localparam logic [7:0] INTERVAL_RESET = 8'h00;
  localparam logic [7:0] INTERVAL_MIN = 8'h01;
  localparam logic [7:0] INTERVAL_MAX = 8'h3E;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 250_000_000;
  localparam int TICK_SECONDS = 1;
  localparam int TICK_CYCLES = CLOCK_HZ * TICK_SECONDS;
  // reset pulse length in cycles
  localparam logic [7:0] RESET_PULSE_CYCLES = 8'h10;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    WDT_IDLE = 2'b00,
    WDT_RUN = 2'b01,
    WDT_FIRE = 2'b10
  } wdt_state_e;

endpackage

/* rtl/wdt_io_port_watchdog.sv */
// watchdog timer reached through one 8-bit i/o port
`timescale 1ns/1ps

module wdt_io_port_watchdog #(
  parameter int TICK_COUNT = wdt_pkg::TICK_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_irq_mode,
  input wire logic i_irq_ack,
  output logic [7:0] o_io_rdata,
  output logic o_cpu_reset,
  output logic o_irq,
  output logic o_running
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // countdown live
  function automatic logic is_run(input wdt_pkg::wdt_state_e s);
    is_run = (s == wdt_pkg::WDT_RUN);
  endfunction

  // cpu reset pulse being driven
  function automatic logic is_fire(input wdt_pkg::wdt_state_e s);
    is_fire = (s == wdt_pkg::WDT_FIRE);
  endfunction

  // ----------------------------------------------------------------
  // mode pin synchroniser
  // ----------------------------------------------------------------
  // the mode level comes from a board pin: two flops before any use
  logic [1:0] mode_sync_r;
  logic irq_mode_s;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      mode_sync_r <= 2'h0;
    else
      mode_sync_r <= {mode_sync_r[0], i_irq_mode};
  end

  assign irq_mode_s = mode_sync_r[1];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire hit = (i_io_addr == wdt_pkg::WATCHDOG_INTERVAL_PORT);
  wire do_write = hit && i_io_wr;
  wire do_read = hit && i_io_rd && !i_io_wr;

  wdt_pkg::wdt_state_e state_r;
  wdt_pkg::wdt_state_e state_nxt;
  logic [27:0] tick_cnt_r;
  logic [7:0] sec_cnt_r;
  logic [7:0] interval_r;
  logic [7:0] pulse_cnt_r;
  logic irq_r;

  // ----------------------------------------------------------------
  // timing decode
  // ----------------------------------------------------------------
  wire run = is_run(state_r);
  // one-cycle enable, once per second of countdown
  wire tick = run && (tick_cnt_r == 28'(TICK_COUNT - 1));
  wire expire = tick && (sec_cnt_r <= 8'h01);
  wire pulse_done = (pulse_cnt_r == 8'h01);
  wire fire_start = run && is_fire(state_nxt);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      wdt_pkg::WDT_IDLE:
      begin
        if (do_write)
          state_nxt = wdt_pkg::WDT_RUN;
      end
      wdt_pkg::WDT_RUN:
      begin
        if (do_write)
          state_nxt = wdt_pkg::WDT_RUN;
        else if (do_read)
          state_nxt = wdt_pkg::WDT_IDLE;
        else if (expire)
          state_nxt = irq_mode_s ? wdt_pkg::WDT_IDLE
                                 : wdt_pkg::WDT_FIRE;
      end
      wdt_pkg::WDT_FIRE:
      begin
        // a write ends the pulse early and starts a new countdown
        if (do_write)
          state_nxt = wdt_pkg::WDT_RUN;
        else if (pulse_done)
          state_nxt = wdt_pkg::WDT_IDLE;
      end
      default:
        state_nxt = wdt_pkg::WDT_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      state_r <= wdt_pkg::WDT_IDLE;
    else
      state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  // a write restarts the prescaler so the first second is whole
  wire tick_clear = do_write || !run || tick;
  wire [27:0] tick_cnt_nxt = tick_clear ? 28'h000_0000
                                        : tick_cnt_r + 28'h000_0001;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      tick_cnt_r <= 28'h000_0000;
    else
      tick_cnt_r <= tick_cnt_nxt;
  end

  // ----------------------------------------------------------------
  // seconds count
  // ----------------------------------------------------------------
  // code 00 still runs one whole second before expiry
  wire sec_step = tick && (sec_cnt_r != 8'h00);
  wire [7:0] sec_cnt_nxt = do_write ? i_io_wdata
                         : sec_step ? sec_cnt_r - 8'h01
                         : sec_cnt_r;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      sec_cnt_r <= wdt_pkg::INTERVAL_RESET;
    else
      sec_cnt_r <= sec_cnt_nxt;
  end

  // last code written, returned by a read
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      interval_r <= wdt_pkg::INTERVAL_RESET;
    else if (do_write)
      interval_r <= i_io_wdata;
  end

  // ----------------------------------------------------------------
  // reset pulse
  // ----------------------------------------------------------------
  wire [7:0] pulse_cnt_nxt = fire_start ? wdt_pkg::RESET_PULSE_CYCLES
                           : (pulse_cnt_r != 8'h00) ? pulse_cnt_r - 8'h01
                           : pulse_cnt_r;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      pulse_cnt_r <= 8'h00;
    else
      pulse_cnt_r <= pulse_cnt_nxt;
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // a new expiry wins over an acknowledge in the same cycle
  wire irq_set = expire && irq_mode_s && !do_write && !do_read;

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      irq_r <= 1'b0;
    else if (irq_set)
      irq_r <= 1'b1;
    else if (i_irq_ack)
      irq_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // a read returns the last code and stops the countdown
  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
      o_io_rdata <= 8'h00;
    else if (do_read)
      o_io_rdata <= interval_r;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_cpu_reset = is_fire(state_r);
  assign o_irq = irq_r;
  assign o_running = run;

endmodule

/* tb/wdt_monitor.sv */
// port assertions for the i/o port watchdog
`timescale 1ns/1ps
module wdt_monitor (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic o_cpu_reset,
  input wire logic o_irq,
  input wire logic o_running
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  wire hit = i_io_addr == wdt_pkg::WATCHDOG_INTERVAL_PORT;
  wire wr = hit && i_io_wr;
  wire rd = hit && i_io_rd && !i_io_wr;
  property p_wr; wr |=> o_running; endproperty
  a_wr: assert property (p_wr) else $error("no start");
  property p_min; wr ##1 !rd [*7] |=> o_running; endproperty
  a_min: assert property (p_min) else $error("early end");
  property p_rd; rd |=> !o_running; endproperty
  a_rd: assert property (p_rd) else $error("no stop");
  // cycles the cpu reset has stood so far
  logic [4:0] rst_len_r;
  always_ff @(posedge i_clock or negedge i_nrst)
    if (!i_nrst)
      rst_len_r <= 5'h00;
    else
      rst_len_r <= o_cpu_reset ? rst_len_r + 5'h01 : 5'h00;
  property p_rst;
    $fell(o_cpu_reset) && !$past(wr) |->
      $past(rst_len_r) == 5'(wdt_pkg::RESET_PULSE_CYCLES - 8'h01);
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset length");
  property p_irq; $rose(o_irq) |-> $fell(o_running); endproperty
  a_irq: assert property (p_irq) else $error("stray irq");
  property p_idle; !o_running && !wr |=> !o_running; endproperty
  a_idle: assert property (p_idle) else $error("self start");
  cover property (rd && o_running);
  cover property ($rose(o_irq));
  cover property ($rose(o_cpu_reset));
endmodule

/* tb/wdt_io_port_watchdog_tb.sv */
// self-checking bench for the i/o port watchdog
`timescale 1ns/1ps
module wdt_io_port_watchdog_tb;
  logic i_clock = 0;
  logic i_nrst = 0;
  logic [15:0] i_io_addr = 16'h0443;
  logic i_io_wr = 0;
  logic i_io_rd = 0;
  logic [7:0] i_io_wdata = 8'h00;
  logic i_irq_mode = 0;
  logic i_irq_ack = 0;
  logic [7:0] o_io_rdata;
  logic o_cpu_reset, o_irq, o_running;
  int n_fail = 0;
  int num_checks = 0;
  int c;
  localparam int TICK = 10;
  always #2 i_clock = ~i_clock;
  wdt_io_port_watchdog #(.TICK_COUNT(TICK)) u_dut (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_io_addr(i_io_addr),
    .i_io_wr(i_io_wr),
    .i_io_rd(i_io_rd),
    .i_io_wdata(i_io_wdata),
    .i_irq_mode(i_irq_mode),
    .i_irq_ack(i_irq_ack),
    .o_io_rdata(o_io_rdata),
    .o_cpu_reset(o_cpu_reset),
    .o_irq(o_irq),
    .o_running(o_running)
  );
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_io_wr = w;
    i_io_rd = !w;
    i_io_addr = a;
    i_io_wdata = d;
    @(negedge i_clock);
    i_io_wr = 0;
    i_io_rd = 0;
  endtask
  task run_len();
    c = 0;
    while (o_running && c < 700)
    begin
      @(negedge i_clock);
      c++;
    end
    if (c >= 700)
    begin
      n_fail++;
      $display("[FAIL] run_len timeout exp below 700 seen %0d", c);
      give_verdict();
    end
  endtask
  task s_len(input logic [7:0] n);
    acc(1, 16'h0443, n);
    run_len();
    chk("len", c, n * TICK);
    chk("cpu_reset", o_cpu_reset, 1);
    chk("irq", o_irq, 0);
    repeat (20) @(negedge i_clock);
  endtask
  task s_refresh_read();
    acc(1, 16'h0443, 8'h02);
    repeat (15) @(negedge i_clock);
    acc(1, 16'h0443, 8'h02);
    repeat (12) @(negedge i_clock);
    chk("running", o_running, 1);
    acc(0, 16'h0443, 8'h00);
    chk("running", o_running, 0);
    chk("rdata", o_io_rdata, 8'h02);
    repeat (40) @(negedge i_clock);
    chk("cpu_reset", o_cpu_reset, 0);
  endtask
  task s_irq();
    i_irq_mode = 1;
    acc(1, 16'h0443, 8'h01);
    run_len();
    chk("cpu_reset", o_cpu_reset, 0);
    repeat (5) @(negedge i_clock);
    chk("irq", o_irq, 1);
    i_irq_ack = 1;
    @(negedge i_clock);
    i_irq_ack = 0;
    @(negedge i_clock);
    chk("irq", o_irq, 0);
  endtask
  initial
  begin
    repeat (12) @(negedge i_clock);
    i_nrst = 1;
    acc(1, 16'h0444, 8'h01);
    chk("running", o_running, 0);
    s_len(8'h01);
    s_len(8'h3E);
    s_refresh_read();
    s_irq();
    give_verdict();
  end
endmodule
bind wdt_io_port_watchdog wdt_monitor u_mon (
  .i_clock(i_clock),
  .i_nrst(i_nrst),
  .i_io_addr(i_io_addr),
  .i_io_wr(i_io_wr),
  .i_io_rd(i_io_rd),
  .o_cpu_reset(o_cpu_reset),
  .o_irq(o_irq),
  .o_running(o_running)
);
